/* File: src/tlvi_core.sv */
// Two-level vectored interrupt unit: sampling, arbitration, vectors, registers.
`timescale 1ns/1ns
module tlvi_core #(
    parameter logic [3:0] RELOC_NIBBLE = tlvi_pkg::RELOC_NIBBLE_64K
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Special-function-register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Core-integrated peripheral requests
    input wire logic timer_zero_overflow_flag,
    input wire logic timer_one_overflow_flag,
    input wire logic uart_one_irq,
    input wire logic timer_two_flag,
    input wire logic uart_two_lin_irq,
    input wire logic i2c_master_irq,
    input wire logic watchdog_one_irq,
    // On-chip peripheral requests outside the core
    input wire logic low_voltage_irq,
    input wire logic touch_cmp_irq,
    input wire logic adc_irq,
    input wire logic pwm_group_irq,
    input wire logic spi_i2cs_irq,
    input wire logic timer_buzzer_group_irq,
    input wire logic mem_error_irq,
    // Expanded pin groups
    input wire logic pin_group_zero_irq,
    input wire logic pin_group_one_irq,
    // Debug sources
    input wire logic breakpoint_irq,
    input wire logic debug_port_irq,
    // Core sequencer handshake
    output logic irq_req,
    output logic [15:0] irq_vector,
    input wire logic irq_ack,
    input wire logic irq_return,
    // Self-clearing flag strobes back to the timers
    output logic timer_zero_flag_clear,
    output logic timer_one_flag_clear
);
    import tlvi_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (RELOC_NIBBLE != 4'h3 && RELOC_NIBBLE != 4'h7 && RELOC_NIBBLE != 4'hB
        && RELOC_NIBBLE != 4'hF) begin : g_bad_nibble
        $error("Relocation nibble must be the top 4KB of 16K/32K/48K/64K.");
    end

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [7:0] interrupt_enable_main;  // Global and main source enables.
    logic [7:0] enable_ext;             // Extended source enables.
    logic [7:0] prio_main;              // Main source priorities.
    logic [7:0] prio_ext;               // Extended source priorities.
    logic vector_relocate_select;       // Moves vectors into boot space.
    logic i2c_mst_flag;                 // Sticky I2C master flag.
    logic [15:0] req_s;                 // Sampled ranked requests.
    logic debug_s;                      // Sampled debug request.
    logic brk_s;                        // Sampled breakpoint request.
    logic [3:0] win_rank;               // Rank behind the presented vector.
    tlvi_level_e win_level;             // Level behind the presented vector.

    // ------------------------------------------------------------
    // Combinational arbitration signals
    // ------------------------------------------------------------
    logic [15:0] en16;                  // Enable per rank.
    logic [15:0] pri16;                 // High-level mark per rank.
    logic [15:0] pend;                  // Requests both pending and enabled.
    logic hi_found;
    logic lo_found;
    logic [3:0] hi_idx;
    logic [3:0] lo_idx;
    logic [3:0] next_rank;
    tlvi_level_e next_level;
    logic [15:0] next_vector;
    logic [3:0] tbl_idx;
    logic [15:0] norm_vec;
    logic take;
    logic wr_exif;

    tlvi_svc_if svc ();

    // ------------------------------------------------------------
    // Request sampling
    // ------------------------------------------------------------

    // All requests come from logic on this clock, so a single stage
    // samples them; rank 0 is the memory-error source, rank 8 is the
    // I2C master flag held here.
    always_ff @(posedge clk) begin
        if (srst) begin
            req_s <= 16'h0000;
            debug_s <= 1'b0;
            brk_s <= 1'b0;
        end else if (ce) begin
            req_s <= {timer_buzzer_group_irq, spi_i2cs_irq, pwm_group_irq,
                      watchdog_one_irq, adc_irq, touch_cmp_irq, low_voltage_irq,
                      i2c_mst_flag, uart_two_lin_irq, timer_two_flag, uart_one_irq,
                      timer_one_overflow_flag, pin_group_one_irq,
                      timer_zero_overflow_flag, pin_group_zero_irq,
                      mem_error_irq};
            debug_s <= debug_port_irq;
            brk_s <= breakpoint_irq;
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------

    // The memory-error source has no enable bit of its own and runs at
    // the low level; only the global enable gates it.
    assign en16 = {enable_ext, interrupt_enable_main[6:0], 1'b1};
    assign pri16 = {prio_ext, prio_main[6:0], 1'b0};
    assign pend = req_s & en16 & {16{interrupt_enable_main[IE_GLOBAL_BIT]}};

    tlvi_first_set #(.WIDTH(NUM_RANKED), .IDXW(4)) u_pick_high (
        .req(pend & pri16),
        .found(hi_found),
        .idx(hi_idx)
    );

    tlvi_first_set #(.WIDTH(NUM_RANKED), .IDXW(4)) u_pick_low (
        .req(pend & ~pri16),
        .found(lo_found),
        .idx(lo_idx)
    );

    // Rank r sits at table row r-1; rank 0 wraps to the last row.
    assign tbl_idx = 4'(next_rank - 4'h1);
    assign norm_vec = VEC_BASE + {9'h000, tbl_idx, 3'b000};

    // Pick the winner by level, debug first, then breakpoint, then the
    // high group and the low group, each in natural rank order.
    always_comb begin
        next_rank = 4'h0;
        next_level = TLVI_LVL_NONE;
        next_vector = 16'h0000;
        if (debug_s) begin
            next_level = TLVI_LVL_DEBUG;
            next_vector = {RELOC_NIBBLE, VEC_OFS_DEBUG};
        end else if (brk_s) begin
            next_level = TLVI_LVL_DEBUG;
            next_vector = {RELOC_NIBBLE, VEC_OFS_BRK};
        end else if (hi_found) begin
            next_rank = hi_idx;
            next_level = TLVI_LVL_HIGH;
        end else if (lo_found) begin
            next_rank = lo_idx;
            next_level = TLVI_LVL_LOW;
        end
        if (next_level == TLVI_LVL_HIGH || next_level == TLVI_LVL_LOW) begin
            if (vector_relocate_select) begin
                next_vector = {RELOC_NIBBLE, norm_vec[11:0]};
            end else begin
                next_vector = norm_vec;
            end
        end
    end

    // A routine in service blocks equal and lower levels.
    assign take = (next_level > svc.active_level);

    // ------------------------------------------------------------
    // Vector presentation
    // ------------------------------------------------------------

    // The request drops in the cycle after a take so a stale copy is
    // never acknowledged twice.
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_req <= 1'b0;
            irq_vector <= 16'h0000;
            win_rank <= 4'h0;
            win_level <= TLVI_LVL_NONE;
        end else if (ce) begin
            irq_req <= take && !(irq_ack && irq_req);
            irq_vector <= next_vector;
            win_rank <= next_rank;
            win_level <= next_level;
        end
    end

    assign svc.push = irq_ack && irq_req;
    assign svc.push_level = win_level;
    assign svc.pop = irq_return;

    tlvi_service_track u_track (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .svc(svc)
    );

    // Timer zero and one flags live in the timer; a one-cycle strobe
    // clears them when their vector is taken. Other flags stay set.
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_zero_flag_clear <= 1'b0;
            timer_one_flag_clear <= 1'b0;
        end else if (ce) begin
            timer_zero_flag_clear <= svc.push && win_rank == RANK_TMR0
                                     && win_level != TLVI_LVL_DEBUG;
            timer_one_flag_clear <= svc.push && win_rank == RANK_TMR1
                                    && win_level != TLVI_LVL_DEBUG;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------

    // Enable, priority and relocation registers; relocation keeps only
    // its selection bit, the other addressing bits belong elsewhere.
    always_ff @(posedge clk) begin
        if (srst) begin
            interrupt_enable_main <= RST_REG;
            enable_ext <= RST_REG;
            prio_main <= RST_REG;
            prio_ext <= RST_REG;
            vector_relocate_select <= 1'b0;
        end else if (ce && sfr_wr) begin
            case (sfr_addr)
                ADDR_IEN: interrupt_enable_main <= sfr_wdata;
                ADDR_EXIE: enable_ext <= sfr_wdata;
                ADDR_IP: prio_main <= {1'b0, sfr_wdata[6:0]};
                ADDR_EXIP: prio_ext <= sfr_wdata;
                ADDR_ACON: vector_relocate_select <= sfr_wdata[ACON_RELOC_BIT];
                default: begin
                end
            endcase
        end
    end

    assign wr_exif = sfr_wr && sfr_addr == ADDR_EXIF;

    // The I2C master flag is set by its pulse and cleared by writing
    // zero; a write of one does nothing, and a set in the clearing
    // cycle wins so no event is lost.
    always_ff @(posedge clk) begin
        if (srst) begin
            i2c_mst_flag <= 1'b0;
        end else if (ce) begin
            if (i2c_master_irq) begin
                i2c_mst_flag <= 1'b1;
            end else if (wr_exif && !sfr_wdata[EXIF_MST_BIT]) begin
                i2c_mst_flag <= 1'b0;
            end
        end
    end

    // Read data is registered; the other flags in the extended flag
    // register mirror the peripherals, which own and clear them.
    always_ff @(posedge clk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else if (ce) begin
            sfr_hit <= 1'b0;
            sfr_rdata <= 8'h00;
            if (sfr_rd) begin
                sfr_hit <= 1'b1;
                case (sfr_addr)
                    ADDR_IEN: sfr_rdata <= interrupt_enable_main;
                    ADDR_EXIE: sfr_rdata <= enable_ext;
                    ADDR_IP: sfr_rdata <= prio_main;
                    ADDR_EXIP: sfr_rdata <= prio_ext;
                    ADDR_ACON: sfr_rdata <= 8'(vector_relocate_select) << ACON_RELOC_BIT;
                    ADDR_EXIF: sfr_rdata <= {req_s[15:13], 1'b0, req_s[11:9],
                                             i2c_mst_flag};
                    ADDR_STATUS: sfr_rdata <= (8'(svc.hp_active) << STATUS_HP_BIT)
                                              | (8'(svc.lp_active) << STATUS_LP_BIT);
                    default: sfr_hit <= 1'b0;
                endcase
            end
        end
    end
endmodule

/* File: src/tlvi_pkg.sv */
// Constants and types shared by the two-level vectored interrupt unit.
package tlvi_pkg;

    // ------------------------------------------------------------
    // Register addresses on the special-function-register bus
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_IEN = 8'hA8;
    localparam logic [7:0] ADDR_EXIE = 8'hE8;
    localparam logic [7:0] ADDR_IP = 8'hB8;
    localparam logic [7:0] ADDR_EXIP = 8'hF8;
    localparam logic [7:0] ADDR_EXIF = 8'h91;
    localparam logic [7:0] ADDR_ACON = 8'h9D;
    localparam logic [7:0] ADDR_STATUS = 8'hC5;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam int IE_GLOBAL_BIT = 7;
    localparam int ACON_RELOC_BIT = 5;
    localparam int STATUS_HP_BIT = 6;
    localparam int STATUS_LP_BIT = 5;
    localparam int EXIF_MST_BIT = 0;
    localparam int EXIF_RSVD_BIT = 4;

    // ------------------------------------------------------------
    // Natural ranks (0 wins) of the sixteen ranked sources
    // ------------------------------------------------------------
    localparam int NUM_RANKED = 16;
    localparam logic [3:0] RANK_ECC = 4'h0;
    localparam logic [3:0] RANK_TMR0 = 4'h2;
    localparam logic [3:0] RANK_TMR1 = 4'h4;

    // ------------------------------------------------------------
    // Vector layout
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;
    localparam logic [11:0] VEC_OFS_BRK = 12'h080;
    localparam logic [11:0] VEC_OFS_DEBUG = 12'h0C0;
    localparam logic [3:0] RELOC_NIBBLE_64K = 4'hF;

    // Service levels; a larger code is a more urgent level.
    typedef enum logic [1:0] {
        TLVI_LVL_NONE = 2'b00,
        TLVI_LVL_LOW = 2'b01,
        TLVI_LVL_HIGH = 2'b10,
        TLVI_LVL_DEBUG = 2'b11
    } tlvi_level_e;

endpackage

/* File: src/tlvi_svc_if.sv */
// Carrier between the interrupt core and its service-level tracker.
`timescale 1ns/1ns
interface tlvi_svc_if;
    import tlvi_pkg::*;
    logic push;                 // A vector was taken by the core.
    tlvi_level_e push_level;    // Level of the vector taken.
    logic pop;                  // Return from a service routine.
    tlvi_level_e active_level;  // Highest level now in service.
    logic hp_active;            // A high-level routine is in progress.
    logic lp_active;            // A low-level routine is in progress.

    modport ctl (output push, output push_level, output pop,
                 input active_level, input hp_active, input lp_active);
    modport stk (input push, input push_level, input pop,
                 output active_level, output hp_active, output lp_active);
endinterface

/* File: src/tlvi_first_set.sv */
// Lowest-index-wins picker over a request mask.
`timescale 1ns/1ns
module tlvi_first_set #(
    parameter int WIDTH = 16,
    parameter int IDXW = 4
) (
    // Request mask and result
    input wire logic [WIDTH-1:0] req,
    output logic found,
    output logic [IDXW-1:0] idx
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 2 || (1 << IDXW) < WIDTH) begin : g_bad_width
        $error("Index width cannot cover the request mask.");
    end

    // Scan downward so that the lowest set bit is the last one kept.
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = IDXW'(i);
            end
        end
    end
endmodule

/* File: src/tlvi_service_track.sv */
// Tracks which service levels are in progress, one bit per level.
`timescale 1ns/1ns
module tlvi_service_track (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Link to the interrupt core
    tlvi_svc_if.stk svc
);
    import tlvi_pkg::*;

    logic [3:1] busy;       // Bit n set while a level-n routine runs.
    logic [3:1] top_bit;    // One-hot highest busy level.

    // Highest level in service; nested routines stack strictly upward.
    always_comb begin
        top_bit = 3'b000;
        svc.active_level = TLVI_LVL_NONE;
        if (busy[3]) begin
            top_bit = 3'b100;
            svc.active_level = TLVI_LVL_DEBUG;
        end else if (busy[2]) begin
            top_bit = 3'b010;
            svc.active_level = TLVI_LVL_HIGH;
        end else if (busy[1]) begin
            top_bit = 3'b001;
            svc.active_level = TLVI_LVL_LOW;
        end
    end

    assign svc.hp_active = busy[2];
    assign svc.lp_active = busy[1];

    // A return ends the innermost routine; a take marks its level busy.
    // If both land in one cycle, both apply: the return clears the old top level and the take sets its own.
    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 3'b000;
        end else if (ce) begin
            if (svc.push && svc.push_level != TLVI_LVL_NONE) begin
                busy <= (busy & ~(svc.pop ? top_bit : 3'b000))
                        | (3'b001 << (svc.push_level - 2'd1));
            end else if (svc.pop) begin
                busy <= busy & ~top_bit;
            end
        end
    end
endmodule

/* File: verification/tlvi_core_monitor.sv */
// Concurrent checks on the ports of the interrupt core.
`timescale 1ns/1ns
module tlvi_core_monitor
    import tlvi_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Sources watched
    input wire logic timer_zero_overflow_flag,
    input wire logic breakpoint_irq,
    input wire logic debug_port_irq,
    // Sequencer handshake and clear strobes
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic irq_ack,
    input wire logic timer_zero_flag_clear,
    input wire logic timer_one_flag_clear
);
    // ------------------------------------------------------------
    // One clock domain, so one default clocking and disable.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_read_hit;
        (ce && sfr_rd && sfr_addr == ADDR_IEN) |=> sfr_hit;
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("mapped read gave no hit");
    property p_unmapped;
        (ce && sfr_rd && sfr_addr == 8'h00) |=> (!sfr_hit && sfr_rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_hit_cause;
        sfr_hit |-> $past(ce && sfr_rd);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without a read");
    property p_ack_drop;
        (ce && irq_req && irq_ack) |=> !irq_req;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("offer stayed after ack");
    property p_t0_clear;
        (ce && irq_req && irq_ack && irq_vector[11:0] == 12'h00B)
            |=> timer_zero_flag_clear ##1 !timer_zero_flag_clear;
    endproperty
    a_t0_clear: assert property (p_t0_clear) else $error("timer zero clear pulse bad");
    property p_t1_clear;
        (ce && irq_req && irq_ack && irq_vector[11:0] == 12'h01B) |=> timer_one_flag_clear;
    endproperty
    a_t1_clear: assert property (p_t1_clear) else $error("timer one clear missing");
    property p_clear_cause;
        timer_zero_flag_clear |-> $past(irq_req && irq_ack && irq_vector[11:0] == 12'h00B);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("stray timer clear");
    property p_debug_vec;
        (irq_req && irq_vector[11:0] == VEC_OFS_DEBUG) |-> $past(debug_port_irq, 2);
    endproperty
    a_debug_vec: assert property (p_debug_vec) else $error("debug vector without debug");
    property p_brk_vec;
        (irq_req && irq_vector[11:0] == VEC_OFS_BRK)
            |-> ($past(breakpoint_irq, 2) && !$past(debug_port_irq, 2));
    endproperty
    a_brk_vec: assert property (p_brk_vec) else $error("breakpoint vector wrong");
    property p_t0_vec;
        (irq_req && irq_vector[11:0] == 12'h00B) |-> $past(timer_zero_overflow_flag, 2);
    endproperty
    a_t0_vec: assert property (p_t0_vec) else $error("timer zero vector unsampled");

    // Main scenarios seen at least once.
    c_take: cover property (irq_req && irq_ack);
    c_t1: cover property (timer_one_flag_clear);
    c_debug: cover property (irq_req && irq_vector[11:0] == VEC_OFS_DEBUG);
endmodule

bind tlvi_core tlvi_core_monitor u_mon (.clk(clk), .srst(srst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .timer_zero_overflow_flag(timer_zero_overflow_flag), .breakpoint_irq(breakpoint_irq),
    .debug_port_irq(debug_port_irq), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .timer_zero_flag_clear(timer_zero_flag_clear),
    .timer_one_flag_clear(timer_one_flag_clear));

/* File: verification/tlvi_seq_model.sv */
// Behavioural model of the core sequencer that takes offered vectors.
`timescale 1ns/1ns
module tlvi_seq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control from the bench
    input wire logic ack_en,
    input wire logic slow,
    // Handshake with the interrupt core
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    output logic irq_ack,
    output logic [15:0] taken_vec
);
    int wait_cnt; // Cycles the current offer has waited.

    initial begin
        irq_ack = 1'b0;
        taken_vec = 16'h0000;
        wait_cnt = 0;
    end

    // Ack is raised off the sampling edge and dropped at the next falling edge, one cycle later.
    always @(negedge clk) begin
        if (srst || !ack_en || irq_ack || !irq_req) begin
            irq_ack <= 1'b0;
            wait_cnt <= 0;
        end else if (wait_cnt >= (slow ? 3 : 0)) begin
            irq_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    // The vector is taken at the edge where ack meets the offer.
    always @(posedge clk) begin
        if (irq_ack && irq_req) begin
            taken_vec <= irq_vector;
        end
    end
endmodule

/* File: verification/tlvi_core_tb_top.sv */
// Self-checking bench for the interrupt core.
`timescale 1ns/1ns
module tlvi_core_tb_top;
    import tlvi_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [15:0] src = 16'h0000; // Sources indexed by natural rank.
    logic brk = 1'b0;
    logic dreq = 1'b0;
    logic ce = 1'b1;
    logic irq_return = 1'b0;
    logic ack_en = 1'b0;
    logic slow = 1'b0;
    logic [7:0] sfr_rdata, v;
    logic sfr_hit, h, irq_req, irq_ack, t0_clr, t1_clr;
    logic [15:0] irq_vector, taken_vec;
    int err_total = 0;
    int num_checks = 0;
    logic [7:0] map_addr [7] = '{ADDR_IEN, ADDR_EXIE, ADDR_IP, ADDR_EXIP, ADDR_EXIF, ADDR_ACON,
                                  ADDR_STATUS};

    always #10 clk = ~clk;

    tlvi_core dut (.clk(clk), .srst(srst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .mem_error_irq(src[0]), .pin_group_zero_irq(src[1]), .timer_zero_overflow_flag(src[2]),
        .pin_group_one_irq(src[3]), .timer_one_overflow_flag(src[4]), .uart_one_irq(src[5]),
        .timer_two_flag(src[6]), .uart_two_lin_irq(src[7]), .i2c_master_irq(src[8]),
        .low_voltage_irq(src[9]), .touch_cmp_irq(src[10]), .adc_irq(src[11]),
        .watchdog_one_irq(src[12]), .pwm_group_irq(src[13]), .spi_i2cs_irq(src[14]),
        .timer_buzzer_group_irq(src[15]), .breakpoint_irq(brk), .debug_port_irq(dreq),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return),
        .timer_zero_flag_clear(t0_clr), .timer_one_flag_clear(t1_clr));

    tlvi_seq_model u_seq (.clk(clk), .srst(srst), .ack_en(ack_en), .slow(slow),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .taken_vec(taken_vec));

    // Timers drop their own flags on the clear strobes.
    always @(negedge clk) begin
        if (t0_clr) src[2] <= 1'b0;
        if (t1_clr) src[4] <= 1'b0;
    end

    // ------------------------------------------------------------
    // Bench tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobes are held from one falling edge to the next, so one rising edge takes them.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic hit);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
        hit = sfr_hit;
    endtask

    // Waits a bounded time for an offer, then compares its vector.
    task automatic wait_req(input logic [15:0] exp);
        int n;
        for (n = 0; n < 10 && irq_req !== 1'b1; n++) @(negedge clk);
        if (n == 10) begin
            err_total++;
            conclude();
        end
        chk(irq_vector, exp);
    endtask

    task automatic ret();
        @(negedge clk);
        irq_return = 1'b1;
        @(negedge clk);
        irq_return = 1'b0;
    endtask

    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        // Reset values, hits, and an unmapped read.
        foreach (map_addr[i]) begin
            rd(map_addr[i], v, h);
            chk(v, 8'h00);
            chk(h, 1'b1);
        end
        rd(8'h00, v, h);
        chk({v, 7'h00, h}, 16'h0000);
        wr(ADDR_IEN, 8'hFF);
        rd(ADDR_IEN, v, h);
        chk(v, 8'hFF);
        // Enabled source without the global bit stays silent.
        wr(ADDR_IEN, 8'h02);
        src[2] = 1'b1;
        repeat (4) @(negedge clk);
        chk(irq_req, 1'b0);
        wr(ADDR_IEN, 8'h82);
        wait_req(16'h000B);
        ack_en = 1'b1;
        repeat (4) @(negedge clk);
        chk(src[2], 1'b0);
        rd(ADDR_STATUS, v, h);
        chk(v, 8'h20);
        ret();
        ack_en = 1'b0;
        // Every ranked source alone gives its own vector.
        wr(ADDR_IEN, 8'hFF);
        wr(ADDR_EXIE, 8'hFF);
        for (int r = 0; r < 16; r++) begin
            src[r] = 1'b1;
            wait_req(r == 0 ? 16'h007B : 16'h0003 + 16'(8 * (r - 1)));
            src[r] = 1'b0;
            if (r == 8) wr(ADDR_EXIF, 8'h00);
            repeat (3) @(negedge clk);
            chk(irq_req, 1'b0);
        end
        // High level beats natural rank, then rank decides.
        wr(ADDR_IP, 8'h08);
        src[1] = 1'b1;
        src[4] = 1'b1;
        wait_req(16'h001B);
        wr(ADDR_IP, 8'h00);
        repeat (3) @(negedge clk);
        chk(irq_vector, 16'h0003);
        // A low routine blocks low requests but not a high one.
        slow = 1'b1;
        ack_en = 1'b1;
        repeat (10) @(negedge clk);
        chk(taken_vec, 16'h0003);
        chk(irq_req, 1'b0);
        wr(ADDR_IP, 8'h08);
        repeat (10) @(negedge clk);
        chk(taken_vec, 16'h001B);
        rd(ADDR_STATUS, v, h);
        chk(v, 8'h60);
        chk(src[4:1], 4'b0001);
        ack_en = 1'b0;
        src[1] = 1'b0;
        ret();
        ret();
        rd(ADDR_STATUS, v, h);
        chk(v, 8'h00);
        // Relocated vectors sit in the top nibble region.
        wr(ADDR_ACON, 8'h20);
        src[4] = 1'b1;
        wait_req(16'hF01B);
        src[4] = 1'b0;
        // Debug sources ignore the global bit; debug wins.
        wr(ADDR_IEN, 8'h00);
        brk = 1'b1;
        wait_req(16'hF080);
        dreq = 1'b1;
        wr(ADDR_ACON, 8'h00);
        repeat (2) @(negedge clk);
        chk(irq_vector, 16'hF0C0);
        brk = 1'b0;
        dreq = 1'b0;
        // Writes never set the master flag; its pulse does, and a zero clears it.
        wr(ADDR_EXIF, 8'hFF);
        rd(ADDR_EXIF, v, h);
        chk(v, 8'h00);
        src[8] = 1'b1;
        @(negedge clk);
        src[8] = 1'b0;
        rd(ADDR_EXIF, v, h);
        chk(v, 8'h01);
        wr(ADDR_EXIF, 8'h00);
        ce = 1'b0;
        wr(ADDR_IEN, 8'h55);
        ce = 1'b1;
        rd(ADDR_IEN, v, h);
        chk(v, 8'h00);
        rd(ADDR_EXIF, v, h);
        chk(v, 8'h00);
        conclude();
    end
endmodule
